// file: pkg/pstrap_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the port strap and interrupt pin block
// Assumes: Single 25 MHz clock domain
// Notes:   Two strapped ports; the third port has no strap
//////////////////////////////////////////////////////////////////////////////
package pstrap_pkg;
	localparam int unsigned STRAP_PORTS   = 2;
	localparam int unsigned SYNC_STAGES   = 2;
	localparam logic        IRQ_SEL_GEN   = 1'b0;
	localparam logic        IRQ_SEL_SUSP  = 1'b1;
	localparam logic [1:0]  STRAP_RST_VAL = 2'h0;

	typedef enum logic [1:0] {
		PSTRAP_ST_STANDBY,
		PSTRAP_ST_CAPTURE,
		PSTRAP_ST_RUN
	} pstrap_state_t;
endpackage : pstrap_pkg

// file: pkg/pstrap_sync_if.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Carries one synchroniser's raw input and its settled output
// Assumes: Same clock on both ends
// Notes:   Raw side comes from pins; settled side feeds the main logic
//////////////////////////////////////////////////////////////////////////////
interface pstrap_sync_if #(
	parameter int unsigned WIDTH = 1
);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] settled;

	modport sync (input raw, output settled);
	modport user (output raw, input settled);
endinterface : pstrap_sync_if

// file: hw/pstrap_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-stage synchroniser for a bundle of pin levels
// Assumes: Inputs are asynchronous to ref_clk_i
// Notes:   First stage feeds only the second stage
//////////////////////////////////////////////////////////////////////////////
module pstrap_sync
	import pstrap_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic    ref_clk_i,
	pstrap_sync_if.sync  port_if
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} pstrap_sync_st_t;

	pstrap_sync_st_t st_reg;
	pstrap_sync_st_t st_next;

	always_comb begin
		st_next.meta   = port_if.raw;
		st_next.stable = st_reg.meta;
	end

	// No reset: the stages keep tracking the straps while reset is held,
	// otherwise the capture at release would only see cleared stages
	always_ff @(posedge ref_clk_i) begin
		st_reg <= st_next;
	end

	assign port_if.settled = st_reg.stable;
endmodule : pstrap_sync

// file: hw/pstrap_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Samples port-disable straps at reset release, drives the
//          open-drain interrupt pin in general or suspend mode
// Assumes: rst_i is the active-high, already synchronised form of the
//          device reset; status and hub state inputs are on ref_clk_i
// Notes:   Straps are taken two edges after release, once the pin synchroniser
//          has filled; events before the run state are dropped.
//          The pending flag keeps tracking in suspend mode.
//////////////////////////////////////////////////////////////////////////////
module pstrap_top
	import pstrap_pkg::*;
#(
	parameter int unsigned NPORTS = STRAP_PORTS
) (
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	input  wire logic [NPORTS-1:0] downstream_plus_pin_i,
	input  wire logic [NPORTS-1:0] downstream_minus_pin_i,
	input  wire logic              irq_function_select_i,
	input  wire logic              status_update_i,
	input  wire logic              status_irq_enabled_i,
	input  wire logic              irq_status_write_i,
	input  wire logic              hub_configured_i,
	input  wire logic              hub_suspended_i,
	output logic [NPORTS-1:0]      port_disable_o,
	output logic                   port3_disable_o,
	output logic                   standby_o,
	output logic                   irq_pin_o,
	output logic                   irq_pin_oe_o
);
	typedef struct packed {
		pstrap_state_t     state;
		logic [NPORTS-1:0] disable_bits;
		logic              irq_pending;
		logic              irq_low;
	} pstrap_st_t;

	pstrap_st_t st_reg;
	pstrap_st_t st_next;

	////////////////////////////////////////////////////////////////////////////
	// Strap pin synchroniser
	////////////////////////////////////////////////////////////////////////////
	// Both pins of each port cross together; only their AND is ever used
	pstrap_sync_if #(.WIDTH(2 * NPORTS)) pin_if ();

	assign pin_if.raw = {downstream_minus_pin_i, downstream_plus_pin_i};

	pstrap_sync #(
		.WIDTH (2 * NPORTS)
	) u_pin_sync (
		.ref_clk_i (ref_clk_i),
		.port_if   (pin_if)
	);

	////////////////////////////////////////////////////////////////////////////
	// Settled pins and hub state
	////////////////////////////////////////////////////////////////////////////
	logic [NPORTS-1:0] plus_s;
	logic [NPORTS-1:0] minus_s;
	logic              susp_low;

	assign plus_s  = pin_if.settled[NPORTS-1:0];
	assign minus_s = pin_if.settled[2*NPORTS-1:NPORTS];
	// Unconfigured, or configured but suspended, pulls the line low
	assign susp_low = !hub_configured_i || hub_suspended_i;

	////////////////////////////////////////////////////////////////////////////
	// Next state
	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		unique case (st_reg.state)
			PSTRAP_ST_STANDBY: begin
				// Standby lasts one edge; the unreset synchroniser already holds settled pins
				st_next.state = PSTRAP_ST_CAPTURE;
			end
			PSTRAP_ST_CAPTURE: begin
				st_next.state        = PSTRAP_ST_RUN;
				st_next.disable_bits = plus_s & minus_s;
			end
			PSTRAP_ST_RUN: begin
				// Only a new reset leaves the run state, so straps are taken once
				st_next.state = PSTRAP_ST_RUN;
			end
			default: begin
				// The fourth code of the state type is unused; recover via standby
				st_next.state = PSTRAP_ST_STANDBY;
			end
		endcase
		// Events outside the run state are dropped
		if (st_reg.state == PSTRAP_ST_RUN) begin
			// Set wins over a host clear in the same cycle
			if (status_update_i && status_irq_enabled_i) begin
				st_next.irq_pending = 1'b1;
			end else if (irq_status_write_i) begin
				st_next.irq_pending = 1'b0;
			end
			// The flag counts in either mode; the select only picks what shows
			if (irq_function_select_i == IRQ_SEL_SUSP) begin
				st_next.irq_low = susp_low;
			end else begin
				st_next.irq_low = st_next.irq_pending;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			// Standby: straps cleared, line released
			st_reg.state        <= PSTRAP_ST_STANDBY;
			st_reg.disable_bits <= STRAP_RST_VAL[NPORTS-1:0];
			st_reg.irq_pending  <= 1'b0;
			st_reg.irq_low      <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	////////////////////////////////////////////////////////////////////////////
	assign port_disable_o  = st_reg.disable_bits;
	assign port3_disable_o = 1'b0;
	assign standby_o       = (st_reg.state == PSTRAP_ST_STANDBY);
	// Open drain: data is always low, only the enable moves
	assign irq_pin_o       = 1'b0;
	assign irq_pin_oe_o    = st_reg.irq_low;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////////////////
	// Reset and standby
	chk_reset_idle: assert property (
		@(posedge ref_clk_i) rst_i |=> standby_o && !irq_pin_oe_o && port_disable_o == '0)
		else $error("reset did not leave the block idle");

	chk_standby_release: assert property (
		@(posedge ref_clk_i) rst_i ##1 !rst_i |-> standby_o && !irq_pin_oe_o ##1 !standby_o)
		else $error("standby sequence wrong");

	chk_standby_straps: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) standby_o |-> port_disable_o == '0)
		else $error("straps set during standby");

	chk_oe_run_only: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state != PSTRAP_ST_RUN |-> !irq_pin_oe_o)
		else $error("interrupt line pulled outside the run state");

	// Straps
	chk_capture_next: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_STANDBY |=> st_reg.state == PSTRAP_ST_CAPTURE)
		else $error("capture did not follow standby");

	chk_strap_both_high: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_CAPTURE |=> port_disable_o == $past(plus_s & minus_s))
		else $error("strap capture mismatch");

	chk_strap_held: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_RUN |=> $stable(port_disable_o))
		else $error("strap changed after capture");

	chk_capture_once: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_RUN |=> st_reg.state == PSTRAP_ST_RUN)
		else $error("run state left without reset");

	chk_port3_never: assert property (
		@(posedge ref_clk_i) !port3_disable_o)
		else $error("port 3 disabled");

	// General interrupt signalling
	chk_irq_gen_fall: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_RUN && irq_function_select_i == IRQ_SEL_GEN
		&& status_update_i && status_irq_enabled_i |=> irq_pin_oe_o)
		else $error("general irq did not fall");

	chk_irq_gen_quiet: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		!irq_pin_oe_o && irq_function_select_i == IRQ_SEL_GEN && $stable(irq_function_select_i)
		&& !(status_update_i && status_irq_enabled_i) |=> !irq_pin_oe_o)
		else $error("general irq fell with no enabled update");

	chk_irq_gen_hold: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		irq_pin_oe_o && irq_function_select_i == IRQ_SEL_GEN
		&& $stable(irq_function_select_i) && !irq_status_write_i |=> irq_pin_oe_o)
		else $error("general irq released without host update");

	chk_irq_gen_clear: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_RUN && irq_function_select_i == IRQ_SEL_GEN
		&& irq_status_write_i && !status_update_i |=> !irq_pin_oe_o)
		else $error("general irq not released");

	chk_irq_set_wins: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_RUN && irq_function_select_i == IRQ_SEL_GEN
		&& status_update_i && status_irq_enabled_i && irq_status_write_i |=> irq_pin_oe_o)
		else $error("host clear beat a new event");

	chk_pending_in_susp: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_RUN && irq_function_select_i == IRQ_SEL_SUSP
		&& status_update_i && status_irq_enabled_i |=> st_reg.irq_pending)
		else $error("event lost in suspend mode");

	// Suspend-state signalling
	chk_irq_susp_low: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_RUN && irq_function_select_i == IRQ_SEL_SUSP
		&& susp_low |=> irq_pin_oe_o)
		else $error("suspend irq not low");

	chk_irq_susp_high: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		st_reg.state == PSTRAP_ST_RUN && irq_function_select_i == IRQ_SEL_SUSP
		&& hub_configured_i && !hub_suspended_i |=> !irq_pin_oe_o)
		else $error("suspend irq not released");

	// Open-drain pin
	chk_never_high: assert property (
		@(posedge ref_clk_i) irq_pin_o == 1'b0)
		else $error("interrupt pin driven high");
endmodule : pstrap_top

// file: sim/pstrap_host_model.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Host SoC servicing the interrupt wire
// Assumes: Wire is pulled up; low means an interrupt is pending
// Notes:   Writes the status register ack_dly_i cycles after seeing it low
//////////////////////////////////////////////////////////////////////////////
module pstrap_host_model (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       irq_wire_i,
	input  wire logic       serve_en_i,
	input  wire logic [3:0] ack_dly_i,
	output logic            irq_status_write_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_reg = 4'h0;
	initial irq_status_write_o = 1'b0;
	// Each write restarts the count at once; it does not wait for the line to rise before counting again
	always @(posedge ref_clk_i) begin
		irq_status_write_o <= 1'b0;
		if (rst_i || irq_wire_i || !serve_en_i || irq_status_write_o) begin
			wait_reg <= 4'h0;
		end else if (wait_reg == ack_dly_i) begin
			irq_status_write_o <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule : pstrap_host_model

// file: sim/tb_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the strap and interrupt pin block
// Assumes: Host model is the only source of status register writes
// Notes:   Random straps and hub states from a fixed seed
//////////////////////////////////////////////////////////////////////////////
module tb_top;
	import pstrap_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk_i;
	logic       rst_i = 1'b1, sel = 1'b0, upd = 1'b0, upd_en = 1'b0, serve = 1'b0;
	logic       cfg = 1'b0, susp = 1'b0, wr, pd3, stby, irq_d, oe;
	logic [1:0] plus = 2'h0, minus = 2'h0, pd;
	logic [3:0] dly = 4'h0, r;
	int         fails = 0, checks = 0;
	integer     seed = 32'h0000_85d0;
	pstrap_top u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .downstream_plus_pin_i(plus),
		.downstream_minus_pin_i(minus), .irq_function_select_i(sel), .status_update_i(upd),
		.status_irq_enabled_i(upd_en), .irq_status_write_i(wr), .hub_configured_i(cfg),
		.hub_suspended_i(susp), .port_disable_o(pd), .port3_disable_o(pd3),
		.standby_o(stby), .irq_pin_o(irq_d), .irq_pin_oe_o(oe));
	pstrap_host_model u_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .irq_wire_i(~oe),
		.serve_en_i(serve), .ack_dly_i(dly), .irq_status_write_o(wr));
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic close_out();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("standby", 2'h1, {1'b0, stby});
		chk("oe_reset", 2'h0, {1'b0, oe});
		chk("pd_reset", 2'h0, pd);
		@(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("standby_run", 2'h0, {1'b0, stby});
	endtask : do_reset
	task automatic pulse(input logic en);
		@(posedge ref_clk_i);
		upd    <= 1'b1;
		upd_en <= en;
		@(posedge ref_clk_i);
		upd <= 1'b0;
		@(negedge ref_clk_i);
	endtask : pulse
	// Open-drain: the data bit must never be high
	always @(negedge ref_clk_i) chk("irq_data", 2'h0, {1'b0, irq_d});
	initial begin
		repeat (3000) @(posedge ref_clk_i);
		fails++;
		close_out();
	end
	initial begin
		for (int i = 0; i < 8; i++) begin
			r = (i == 0) ? 4'hf : (i == 1) ? 4'h3 : 4'($random(seed));
			@(posedge ref_clk_i);
			plus  <= r[1:0];
			minus <= r[3:2];
			do_reset();
			chk("port_disable", r[1:0] & r[3:2], pd);
			chk("port3", 2'h0, {1'b0, pd3});
			@(posedge ref_clk_i);
			plus  <= ~r[1:0];
			minus <= ~r[3:2];
			repeat (3) @(negedge ref_clk_i);
			chk("strap_hold", r[1:0] & r[3:2], pd);
		end
		pulse(1'b0);
		chk("irq_not_enabled", 2'h0, {1'b0, oe});
		pulse(1'b1);
		chk("irq_set", 2'h1, {1'b0, oe});
		repeat (5) @(negedge ref_clk_i);
		chk("irq_held", 2'h1, {1'b0, oe});
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			serve <= 1'b1;
			dly   <= 4'($random(seed));
			for (int k = 0; k < 30 && oe !== 1'b0; k++) @(negedge ref_clk_i);
			chk("irq_release", 2'h0, {1'b0, oe});
			pulse(1'b1);
			chk("irq_again", 2'h1, {1'b0, oe});
		end
		repeat (30) @(negedge ref_clk_i);
		// Enabled event in the very cycle of the host write: the event must win
		dly <= 4'h0;
		pulse(1'b1);
		@(posedge ref_clk_i);
		upd <= 1'b1;
		@(posedge ref_clk_i);
		upd <= 1'b0;
		@(negedge ref_clk_i);
		chk("set_wins", 2'h1, {1'b0, oe});
		@(posedge ref_clk_i);
		serve <= 1'b0;
		sel   <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			r = 4'($random(seed));
			@(posedge ref_clk_i);
			cfg  <= r[0];
			susp <= r[1];
			@(posedge ref_clk_i);
			@(negedge ref_clk_i);
			chk("suspend_pin", {1'b0, ~r[0] | r[1]}, {1'b0, oe});
		end
		@(posedge ref_clk_i);
		cfg  <= 1'b1;
		susp <= 1'b0;
		pulse(1'b1);
		@(negedge ref_clk_i);
		chk("susp_ignores_irq", 2'h0, {1'b0, oe});
		@(posedge ref_clk_i);
		sel <= 1'b0;
		repeat (2) @(negedge ref_clk_i);
		chk("pending_shown", 2'h1, {1'b0, oe});
		// Reset while the line is pulled must release it
		do_reset();
		chk("oe_after_reset", 2'h0, {1'b0, oe});
		close_out();
	end
endmodule : tb_top
